/* File: hdlc_defines.svh */
// Named constants for the overhead-bit HDLC controller.
// Assumes one includer per compile unit; guarded against double inclusion.
`ifndef HDLC_DEFINES_SVH
`define HDLC_DEFINES_SVH
`define A_CTRL 12'h000
`define A_WM 12'h004
`define A_STAT 12'h008
`define A_INFO 12'h00C
`define A_RXDATA 12'h010
`define A_TXDATA 12'h014
`define C_CRCD 0
`define C_CRCI 1
`define C_ZSD 2
`define C_FILL 3
`define C_TXINV 4
`define C_RXINV 5
`define C_TXRST 6
`define C_RXRST 7
`define C_MODE_LO 8
`define C_MODE_HI 9
`define C_SNS0 10
`define C_SNS1 11
`define W_TX_LO 0
`define W_TX_HI 2
`define W_RX_LO 4
`define W_RX_HI 6
`define S_TEND 0
`define S_TUDR 1
`define S_TLWM 2
`define S_RHWM 3
`define S_RABT 4
`define S_RPS 5
`define S_RPE 6
`define S_ROVR 7
`define MODE_M23 2'h0
`define MODE_CBIT 2'h1
`define MODE_E3 2'h2
`define SN_SRC_HDLC 2'h1
`define FLAG_BYTE 8'h7E
`define IDLE_BYTE 8'hFF
`define ABORT_BYTE 8'hFE
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hF0B8
`define FIFO_DEPTH 9'h100
`define TX_START_LEVEL 9'h002
`define WM_BASE 9'h010
`define WM_STEP 9'h020
`define PS_OK 2'h0
`define PS_CRC 2'h1
`define PS_ABORT 2'h2
`define PS_ALIGN 2'h3
`define ONES_FLAG 3'h6
`define ONES_STUFF 3'h5
`define ONES_MAX 3'h7
`define BIT_LAST 3'h7
`define HOLD_FULL 2'h3
`endif

/* File: hdlc_pkg.sv */
// Types shared by the overhead-bit HDLC controller.
// Assumes hdlc_defines.svh holds the numeric constants.
package hdlc_pkg;
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_IDLE = 2'h1,
    RX_PKT = 2'h2
  } rx_state_type;
  typedef enum logic [2:0] {
    TX_ABORT = 3'h0,
    TX_FILL = 3'h1,
    TX_OPEN = 3'h2,
    TX_DATA = 3'h3,
    TX_CRCLO = 3'h4,
    TX_CRCHI = 3'h5,
    TX_CLOSE = 3'h6
  } tx_state_type;
endpackage

/* File: hdlc_overhead_link_controller.sv */
// HDLC controller carried in DS3 C-bits or the E3 Sn bit, with an APB slave.
// Assumes the framer gives one-cycle slot strobes synchronous to pclk.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "hdlc_defines.svh"
// What this block does
// (RQ1) Separate 256-byte transmit and receive FIFOs.
// (RQ2) C-bit parity mode uses the three M-subframe 5 C-bits both ways.
// (RQ3) E3 receive always uses Sn; transmit drives Sn per source selects.
// (RQ4) M23 mode carries no traffic and touches no overhead bits.
// (RQ5) Receive reset flushes the FIFO and restarts the flag hunt.
// (RQ6) Receive destuffs zeros, aligns bytes and writes each byte.
// (RQ7) Each stored byte carries a first-of-packet marker.
// (RQ8) Closing flag checks CRC, drops it, marks last byte with status.
// (RQ9) Packets may be split by one flag or flags sharing a zero.
// (RQ10) Overflow discards the packet rest and latches overrun.
// (RQ11) After overflow no packets until FIFO empty or reset.
// (RQ12) Seven ones latch abort; inside a packet store aborted status.
// (RQ13) Events on packet start, packet end and rising over high mark.
// (RQ14) Host pops one receive byte per read; empty flag shown.
// (RQ15) Transmit reset flushes, sends one abort, then flag or idle fill.
// (RQ16) A packet starts only with at least two bytes queued.
// (RQ17) Opening flag first, zero inserted after five ones.
// (RQ18) End marker byte is followed by CRC, closing flag, then fill.
// (RQ19) At least two flags between packets; next opens automatically.
// (RQ20) Empty FIFO mid-packet latches underrun, sends abort then fill.
// (RQ21) Packet sent latches packet end; event on falling under low mark.
// (RQ22) Transmit FIFO level is readable to avoid overfill.
// (RQ23) Fill select zero sends flags, one sends idle bytes.
// (RQ24) Each reset control acts on a written zero-to-one transition.
// (RQ25) Watermark code maps to 16 plus 32 bytes per step.
// (RQ26) CRC-16-CCITT preset ones, complemented, sent low bit first.
module hdlc_overhead_link_controller (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive overhead slots
  input wire logic rx_cbit_strobe,
  input wire logic rx_sn_strobe,
  input wire logic rx_ohbit,
  // Transmit overhead slots
  input wire logic tx_cbit_strobe,
  input wire logic tx_sn_strobe,
  output logic tx_ohbit,
  output logic tx_ohbit_en
);
  import hdlc_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] wm_level(input logic [2:0] code);
    return `WM_BASE + (`WM_STEP * {6'h00, code});
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return (a == `A_CTRL) || (a == `A_WM) || (a == `A_STAT) || (a == `A_INFO) ||
      (a == `A_RXDATA) || (a == `A_TXDATA);
  endfunction

  logic [11:0] ctrl_reg;
  logic [7:0] wm_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_set;
  logic [31:0] prdata_reg;
  logic [11:0] rx_mem [0:255];
  logic [7:0] rx_wp_reg, rx_rp_reg;
  logic [8:0] rx_cnt_reg;
  logic rx_block_reg;
  logic [8:0] tx_mem [0:255];
  logic [7:0] tx_wp_reg, tx_rp_reg;
  logic [8:0] tx_cnt_reg;
  rx_state_type rx_st_reg;
  logic [2:0] rx_ones_reg, rx_bcnt_reg;
  logic [7:0] rx_asm_reg, rx_h0_reg, rx_h1_reg, rx_h2_reg;
  logic [1:0] rx_hcnt_reg;
  logic rx_started_reg;
  logic [15:0] rx_crc_reg;
  logic rx_push_reg;
  logic [11:0] rx_wdata_reg;
  logic ev_rps_reg, ev_rpe_reg, ev_rabt_reg;
  tx_state_type tx_st_reg;
  logic [7:0] tx_sr_reg;
  logic [2:0] tx_bcnt_reg, tx_ones_reg;
  logic tx_eom_reg;
  logic [15:0] tx_crc_reg;
  logic tx_out_reg;
  logic ev_tend_reg, ev_tudr_reg;
  logic rhwm_prev_reg, tlwm_prev_reg;

  logic acc, wr, rd;
  logic rx_rst, tx_rst;
  logic [1:0] mode;
  logic sn_hdlc;
  logic rx_take, rb, rx_data, rx_flag, rx_abort, rx_byte_end;
  logic [7:0] rx_byte, fill_byte, tx_head;
  logic rx_ovf, rx_pop, rx_wr, tx_push;
  logic tx_go, tx_stuff, tx_byte_end, tx_pop;
  logic [15:0] tx_crc_out;
  logic rhwm_rt, tlwm_rt;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign pready = acc;
  assign pslverr = acc & ~mapped(paddr);
  assign prdata = prdata_reg;
  assign mode = ctrl_reg[`C_MODE_HI:`C_MODE_LO];
  assign sn_hdlc = {ctrl_reg[`C_SNS1], ctrl_reg[`C_SNS0]} == `SN_SRC_HDLC;
  // Resets fire on the written edge, so a bit left high does not hold them.
  assign rx_rst = wr && paddr == `A_CTRL && pwdata[`C_RXRST] && !ctrl_reg[`C_RXRST]; // RQ24
  assign tx_rst = wr && paddr == `A_CTRL && pwdata[`C_TXRST] && !ctrl_reg[`C_TXRST]; // RQ24

  // Receive bits.
  assign rx_take = (mode == `MODE_CBIT && rx_cbit_strobe) || // RQ2 RQ4
    (mode == `MODE_E3 && rx_sn_strobe); // RQ3
  assign rb = rx_ohbit ^ ctrl_reg[`C_RXINV];
  assign rx_flag = rx_take && !rb && rx_ones_reg == `ONES_FLAG; // RQ9
  assign rx_abort = rx_take && rb && rx_ones_reg == `ONES_FLAG; // RQ12
  assign rx_data = rx_take && rx_st_reg != RX_HUNT && !rx_block_reg &&
    (rb ? rx_ones_reg < `ONES_FLAG : rx_ones_reg < `ONES_STUFF); // RQ6
  assign rx_byte_end = rx_data && rx_bcnt_reg == `BIT_LAST;
  assign rx_byte = {rb, rx_asm_reg[7:1]};
  assign rx_ovf = rx_push_reg && rx_cnt_reg == `FIFO_DEPTH;
  assign rx_wr = rx_push_reg && !rx_ovf;
  assign rx_pop = rd && paddr == `A_RXDATA && rx_cnt_reg != 9'h000; // RQ14

  // Receive framing. Three bytes are held back so CRC stays out of the FIFO
  // and the last data byte can still be marked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg <= RX_HUNT;
      rx_ones_reg <= 3'h0;
      rx_bcnt_reg <= 3'h0;
      rx_asm_reg <= 8'h00;
      rx_h0_reg <= 8'h00;
      rx_h1_reg <= 8'h00;
      rx_h2_reg <= 8'h00;
      rx_hcnt_reg <= 2'h0;
      rx_started_reg <= 1'b0;
      rx_crc_reg <= `CRC_INIT;
      rx_push_reg <= 1'b0;
      rx_wdata_reg <= 12'h000;
      ev_rps_reg <= 1'b0;
      ev_rpe_reg <= 1'b0;
      ev_rabt_reg <= 1'b0;
    end else if (rx_rst) begin
      rx_st_reg <= RX_HUNT; // RQ5
      rx_ones_reg <= 3'h0;
      rx_bcnt_reg <= 3'h0;
      rx_hcnt_reg <= 2'h0;
      rx_started_reg <= 1'b0;
      rx_push_reg <= 1'b0;
      ev_rps_reg <= 1'b0;
      ev_rpe_reg <= 1'b0;
      ev_rabt_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      ev_rps_reg <= 1'b0;
      ev_rpe_reg <= 1'b0;
      ev_rabt_reg <= 1'b0;
      if (rx_take) begin
        if (!rb) begin
          rx_ones_reg <= 3'h0;
        end else if (rx_ones_reg != `ONES_MAX) begin
          rx_ones_reg <= rx_ones_reg + 3'h1;
        end
      end
      if (rx_data) begin
        rx_asm_reg <= rx_byte;
        rx_bcnt_reg <= rx_bcnt_reg + 3'h1;
        rx_st_reg <= RX_PKT;
      end
      if (rx_byte_end) begin
        rx_crc_reg <= crc_byte(rx_crc_reg, rx_byte); // RQ26
        rx_h0_reg <= rx_byte;
        rx_h1_reg <= rx_h0_reg;
        rx_h2_reg <= rx_h1_reg;
        if (rx_hcnt_reg == `HOLD_FULL) begin
          rx_push_reg <= 1'b1; // RQ6
          rx_wdata_reg <= {`PS_OK, 1'b0, !rx_started_reg, rx_h2_reg}; // RQ7
          rx_started_reg <= 1'b1;
          ev_rps_reg <= !rx_started_reg; // RQ13
        end else begin
          rx_hcnt_reg <= rx_hcnt_reg + 2'h1;
        end
      end
      if (rx_flag) begin
        if (rx_st_reg == RX_PKT && (rx_started_reg || rx_hcnt_reg == `HOLD_FULL)) begin
          rx_push_reg <= 1'b1;
          ev_rpe_reg <= 1'b1; // RQ13
          if (rx_bcnt_reg != `BIT_LAST || rx_hcnt_reg != `HOLD_FULL) begin
            rx_wdata_reg <= {`PS_ALIGN, 1'b1, !rx_started_reg, rx_h2_reg};
          end else if (rx_crc_reg == `CRC_GOOD) begin
            rx_wdata_reg <= {`PS_OK, 1'b1, !rx_started_reg, rx_h2_reg}; // RQ8
          end else begin
            rx_wdata_reg <= {`PS_CRC, 1'b1, !rx_started_reg, rx_h2_reg}; // RQ8
          end
        end
        rx_st_reg <= rx_block_reg ? RX_HUNT : RX_IDLE; // RQ9
        rx_bcnt_reg <= 3'h0;
        rx_hcnt_reg <= 2'h0;
        rx_started_reg <= 1'b0;
        rx_crc_reg <= `CRC_INIT;
      end
      if (rx_abort) begin
        ev_rabt_reg <= 1'b1; // RQ12
        if (rx_st_reg == RX_PKT && (rx_started_reg || rx_hcnt_reg == `HOLD_FULL)) begin
          rx_push_reg <= 1'b1;
          ev_rpe_reg <= 1'b1;
          rx_wdata_reg <= {`PS_ABORT, 1'b1, !rx_started_reg, rx_h2_reg}; // RQ12
        end
        rx_st_reg <= RX_HUNT;
        rx_started_reg <= 1'b0;
      end
      if (rx_block_reg) begin
        rx_st_reg <= RX_HUNT; // RQ10
        rx_started_reg <= 1'b0;
      end
    end
  end

  // Receive FIFO.
  always_ff @(posedge pclk) begin
    if (rx_wr) begin
      rx_mem[rx_wp_reg] <= rx_wdata_reg; // RQ1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_reg <= 8'h00;
      rx_rp_reg <= 8'h00;
      rx_cnt_reg <= 9'h000;
    end else if (rx_rst) begin
      rx_wp_reg <= 8'h00; // RQ5
      rx_rp_reg <= 8'h00;
      rx_cnt_reg <= 9'h000;
    end else begin
      if (rx_wr) begin
        rx_wp_reg <= rx_wp_reg + 8'h01;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 8'h01;
      end
      rx_cnt_reg <= rx_cnt_reg + {8'h00, rx_wr} - {8'h00, rx_pop};
    end
  end

  // Overflow lock stays until the host drains the FIFO or a receive reset clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_block_reg <= 1'b0;
    end else if (rx_rst) begin
      rx_block_reg <= 1'b0; // RQ11
    end else if (rx_ovf) begin
      rx_block_reg <= 1'b1; // RQ10
    end else if (rx_cnt_reg == 9'h000) begin
      rx_block_reg <= 1'b0; // RQ11
    end
  end

  // Transmit FIFO.
  assign tx_push = wr && paddr == `A_TXDATA && tx_cnt_reg != `FIFO_DEPTH; // RQ22
  assign tx_head = tx_mem[tx_rp_reg][7:0];

  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= pwdata[8:0]; // RQ1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_reg <= 8'h00;
      tx_rp_reg <= 8'h00;
      tx_cnt_reg <= 9'h000;
    end else if (tx_rst) begin
      tx_wp_reg <= 8'h00; // RQ15
      tx_rp_reg <= 8'h00;
      tx_cnt_reg <= 9'h000;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 8'h01;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 8'h01;
      end
      tx_cnt_reg <= tx_cnt_reg + {8'h00, tx_push} - {8'h00, tx_pop};
    end
  end

  // Transmit serialiser, one bit per granted slot.
  assign tx_go = (mode == `MODE_CBIT && tx_cbit_strobe) || // RQ2 RQ4
    (mode == `MODE_E3 && sn_hdlc && tx_sn_strobe); // RQ3
  assign tx_ohbit_en = mode == `MODE_CBIT || (mode == `MODE_E3 && sn_hdlc); // RQ3 RQ4
  assign tx_stuff = !ctrl_reg[`C_ZSD] && tx_ones_reg == `ONES_STUFF &&
    (tx_st_reg == TX_DATA || tx_st_reg == TX_CRCLO || tx_st_reg == TX_CRCHI); // RQ17
  assign tx_byte_end = tx_go && !tx_stuff && tx_bcnt_reg == `BIT_LAST;
  assign tx_pop = tx_byte_end && (tx_st_reg == TX_OPEN ||
    (tx_st_reg == TX_DATA && !tx_eom_reg && tx_cnt_reg != 9'h000));
  assign fill_byte = ctrl_reg[`C_FILL] ? `IDLE_BYTE : `FLAG_BYTE; // RQ23
  assign tx_crc_out = ctrl_reg[`C_CRCI] ? tx_crc_reg : ~tx_crc_reg; // RQ26
  assign tx_ohbit = tx_out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= TX_FILL;
      tx_sr_reg <= `FLAG_BYTE;
      tx_bcnt_reg <= 3'h0;
      tx_ones_reg <= 3'h0;
      tx_eom_reg <= 1'b0;
      tx_crc_reg <= `CRC_INIT;
      tx_out_reg <= 1'b1;
      ev_tend_reg <= 1'b0;
      ev_tudr_reg <= 1'b0;
    end else if (tx_rst) begin
      tx_st_reg <= TX_ABORT; // RQ15
      tx_sr_reg <= `ABORT_BYTE;
      tx_bcnt_reg <= 3'h0;
      tx_ones_reg <= 3'h0;
      ev_tend_reg <= 1'b0;
      ev_tudr_reg <= 1'b0;
    end else begin
      ev_tend_reg <= 1'b0;
      ev_tudr_reg <= 1'b0;
      if (tx_go && tx_stuff) begin
        tx_out_reg <= ctrl_reg[`C_TXINV]; // RQ17
        tx_ones_reg <= 3'h0;
      end else if (tx_go) begin
        tx_out_reg <= tx_sr_reg[0] ^ ctrl_reg[`C_TXINV];
        tx_sr_reg <= {1'b0, tx_sr_reg[7:1]};
        tx_bcnt_reg <= tx_bcnt_reg + 3'h1;
        if (!tx_sr_reg[0]) begin
          tx_ones_reg <= 3'h0;
        end else if (tx_ones_reg != `ONES_MAX) begin
          tx_ones_reg <= tx_ones_reg + 3'h1;
        end
      end
      if (tx_byte_end) begin
        case (tx_st_reg)
          TX_ABORT: begin
            tx_st_reg <= TX_FILL; // RQ15
            tx_sr_reg <= fill_byte;
          end
          TX_FILL: begin
            if (tx_cnt_reg >= `TX_START_LEVEL) begin
              tx_st_reg <= TX_OPEN; // RQ16 RQ19
              tx_sr_reg <= `FLAG_BYTE; // RQ17
            end else begin
              tx_sr_reg <= fill_byte;
            end
          end
          TX_OPEN: begin
            tx_st_reg <= TX_DATA;
            tx_sr_reg <= tx_head;
            tx_eom_reg <= tx_mem[tx_rp_reg][8];
            tx_crc_reg <= crc_byte(`CRC_INIT, tx_head);
          end
          TX_DATA: begin
            if (tx_eom_reg && ctrl_reg[`C_CRCD]) begin
              tx_st_reg <= TX_CLOSE;
              tx_sr_reg <= `FLAG_BYTE;
            end else if (tx_eom_reg) begin
              tx_st_reg <= TX_CRCLO; // RQ18
              tx_sr_reg <= tx_crc_out[7:0];
            end else if (tx_cnt_reg == 9'h000) begin
              tx_st_reg <= TX_ABORT; // RQ20
              tx_sr_reg <= `ABORT_BYTE;
              ev_tudr_reg <= 1'b1;
            end else begin
              tx_sr_reg <= tx_head;
              tx_eom_reg <= tx_mem[tx_rp_reg][8];
              tx_crc_reg <= crc_byte(tx_crc_reg, tx_head);
            end
          end
          TX_CRCLO: begin
            tx_st_reg <= TX_CRCHI;
            tx_sr_reg <= tx_crc_out[15:8];
          end
          TX_CRCHI: begin
            tx_st_reg <= TX_CLOSE;
            tx_sr_reg <= `FLAG_BYTE; // RQ18
          end
          TX_CLOSE: begin
            tx_st_reg <= TX_FILL; // RQ18
            tx_sr_reg <= fill_byte;
            ev_tend_reg <= 1'b1; // RQ21
          end
          default: begin
            tx_st_reg <= TX_ABORT;
            tx_sr_reg <= `ABORT_BYTE;
          end
        endcase
      end
    end
  end

  // Live watermark levels; only a crossing raises an event.
  assign rhwm_rt = rx_cnt_reg > wm_level(wm_reg[`W_RX_HI:`W_RX_LO]); // RQ25
  assign tlwm_rt = tx_cnt_reg < wm_level(wm_reg[`W_TX_HI:`W_TX_LO]); // RQ25

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rhwm_prev_reg <= 1'b0;
      tlwm_prev_reg <= 1'b1;
    end else begin
      rhwm_prev_reg <= rhwm_rt;
      tlwm_prev_reg <= tlwm_rt;
    end
  end

  always_comb begin
    stat_set = 8'h00;
    stat_set[`S_ROVR] = rx_ovf; // RQ10
    stat_set[`S_RPE] = ev_rpe_reg; // RQ13
    stat_set[`S_RPS] = ev_rps_reg; // RQ13
    stat_set[`S_RABT] = ev_rabt_reg; // RQ12
    stat_set[`S_RHWM] = rhwm_rt && !rhwm_prev_reg; // RQ13
    stat_set[`S_TLWM] = tlwm_rt && !tlwm_prev_reg; // RQ21
    stat_set[`S_TUDR] = ev_tudr_reg; // RQ20
    stat_set[`S_TEND] = ev_tend_reg; // RQ21
  end

  // Register file. Latched flags clear by writing one; a new event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 12'h000;
      wm_reg <= 8'h00;
      stat_reg <= 8'h00;
    end else begin
      if (wr && paddr == `A_CTRL) begin
        ctrl_reg <= pwdata[11:0];
      end
      if (wr && paddr == `A_WM) begin
        wm_reg <= pwdata[7:0] & 8'h77;
      end
      if (wr && paddr == `A_STAT) begin
        stat_reg <= (stat_reg & ~pwdata[7:0]) | stat_set;
      end else begin
        stat_reg <= stat_reg | stat_set;
      end
    end
  end

  // Read data is captured at setup and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `A_CTRL: prdata_reg <= {20'h00000, ctrl_reg};
        `A_WM: prdata_reg <= {24'h000000, wm_reg};
        `A_STAT: prdata_reg <= {24'h000000, stat_reg};
        `A_INFO: prdata_reg <= {7'h00, rx_cnt_reg, 3'h0, tlwm_rt, rhwm_rt,
          rx_cnt_reg == 9'h000, tx_cnt_reg == 9'h000, tx_cnt_reg}; // RQ14 RQ22
        `A_RXDATA: prdata_reg <= {20'h00000,
          rx_cnt_reg == 9'h000 ? 12'h000 : rx_mem[rx_rp_reg]};
        default: prdata_reg <= 32'h0;
      endcase
    end
  end
endmodule

/* File: hdlc_overhead_link_controller_chk.sv */
// Port checker for the HDLC controller.
// Assumes CTRL and WM reset to zero.
`timescale 1ns/1ps
`include "hdlc_defines.svh"
module hdlc_overhead_link_controller_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Transmit slots
  input wire logic tx_cbit_strobe,
  input wire logic tx_sn_strobe,
  input wire logic tx_ohbit,
  input wire logic tx_ohbit_en
);
  logic [11:0] ctrl_reg;
  logic [6:0] wm_reg;
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 12'h000;
      wm_reg <= 7'h00;
    end else if (acc && pwrite && paddr == `A_CTRL) begin
      ctrl_reg <= pwdata[11:0];
    end else if (acc && pwrite && paddr == `A_WM) begin
      wm_reg <= pwdata[6:0] & 7'h77;
    end
  end
  property p_m23;
    ctrl_reg[9:8] == `MODE_M23 |-> !tx_ohbit_en;
  endproperty
  a_m23: assert property (p_m23) else $error("M23 slot driven");
  property p_cbit;
    ctrl_reg[9:8] == `MODE_CBIT |-> tx_ohbit_en;
  endproperty
  a_cbit: assert property (p_cbit) else $error("C-bit slot idle");
  property p_e3;
    ctrl_reg[9:8] == `MODE_E3 |-> tx_ohbit_en == (ctrl_reg[11:10] == `SN_SRC_HDLC);
  endproperty
  a_e3: assert property (p_e3) else $error("Sn drive wrong");
  property p_hold;
    !tx_cbit_strobe && !tx_sn_strobe |=> $stable(tx_ohbit);
  endproperty
  a_hold: assert property (p_hold) else $error("tx bit moved");
  property p_wm;
    acc && !pwrite && paddr == `A_WM |-> prdata[6:0] == wm_reg;
  endproperty
  a_wm: assert property (p_wm) else $error("wm readback");
  property p_ctrl;
    acc && !pwrite && paddr == `A_CTRL |-> prdata[11:0] == ctrl_reg;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
  property p_unmapped;
    acc && !pwrite && paddr >= 12'h018 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_mapped;
    acc && paddr <= `A_RXDATA && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped refused");
endmodule
bind hdlc_overhead_link_controller hdlc_overhead_link_controller_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .tx_cbit_strobe(tx_cbit_strobe), .tx_sn_strobe(tx_sn_strobe),
  .tx_ohbit(tx_ohbit), .tx_ohbit_en(tx_ohbit_en)
);

/* File: framer_slot_model.sv */
// Framer slot model looping each transmit slot into a receive slot.
// Assumes gap of at least four; the slot period is gap cycles.
`timescale 1ns/1ps
module framer_slot_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench setup
  input wire logic e3_sel,
  input wire logic [7:0] gap,
  // Slots
  output logic tx_cbit_strobe,
  output logic tx_sn_strobe,
  output logic rx_cbit_strobe,
  output logic rx_sn_strobe,
  output logic rx_ohbit,
  input wire logic tx_ohbit,
  input wire logic tx_ohbit_en,
  output logic [7:0] last8
);
  logic [7:0] ph;
  logic tx_stb, rx_stb, line;
  assign tx_cbit_strobe = tx_stb && !e3_sel;
  assign tx_sn_strobe = tx_stb && e3_sel;
  assign rx_cbit_strobe = rx_stb && !e3_sel;
  assign rx_sn_strobe = rx_stb && e3_sel;
  // An unowned slot toggles, so a stale bit never passes for data.
  assign line = tx_ohbit_en ? tx_ohbit : ~rx_ohbit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 8'h00;
      tx_stb <= 1'b0;
      rx_stb <= 1'b0;
      rx_ohbit <= 1'b1;
      last8 <= 8'h00;
    end else begin
      ph <= (ph + 8'h01 >= gap) ? 8'h00 : ph + 8'h01;
      tx_stb <= (ph == 8'h00);
      rx_stb <= (ph == 8'h02);
      if (ph == 8'h02) begin
        rx_ohbit <= line;
        last8 <= {line, last8[7:1]};
      end else begin
        rx_ohbit <= ~rx_ohbit;
      end
    end
  end
endmodule

/* File: hdlc_overhead_link_controller_test.sv */
// Self-checking bench for the HDLC controller.
// Assumes the slot model loops transmit back to receive.
`timescale 1ns/1ps
`include "hdlc_defines.svh"
module hdlc_overhead_link_controller_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, e3_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic rx_cbit_strobe, rx_sn_strobe, rx_ohbit, tx_cbit_strobe, tx_sn_strobe;
  logic tx_ohbit, tx_ohbit_en;
  logic [7:0] gap, last8;
  logic [11:0] rx_q[$];
  int failures, compares;
  hdlc_overhead_link_controller dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_cbit_strobe(rx_cbit_strobe), .rx_sn_strobe(rx_sn_strobe), .rx_ohbit(rx_ohbit),
    .tx_cbit_strobe(tx_cbit_strobe), .tx_sn_strobe(tx_sn_strobe),
    .tx_ohbit(tx_ohbit), .tx_ohbit_en(tx_ohbit_en));
  framer_slot_model far_end (
    .pclk(pclk), .presetn(presetn), .e3_sel(e3_sel), .gap(gap),
    .tx_cbit_strobe(tx_cbit_strobe), .tx_sn_strobe(tx_sn_strobe),
    .rx_cbit_strobe(rx_cbit_strobe), .rx_sn_strobe(rx_sn_strobe), .rx_ohbit(rx_ohbit),
    .tx_ohbit(tx_ohbit), .tx_ohbit_en(tx_ohbit_en), .last8(last8));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_stat(input int idx);
    rd_data = 32'h0;
    repeat (2000) if (rd_data[idx] !== 1'b1) apb(1'b0, `A_STAT, 32'h0);
    chk("stat", 32'h1, {31'h0, rd_data[idx]});
    apb(1'b1, `A_STAT, 32'h1 << idx);
  endtask
  task automatic send_pkt(input int n, input logic [7:0] base);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = base + 8'(i);
      apb(1'b1, `A_TXDATA, {23'h0, i == n - 1, b});
      rx_q.push_back({2'h0, i == n - 1, i == 0, b});
    end
  endtask
  task automatic drain();
    while (rx_q.size() > 0) begin
      apb(1'b0, `A_RXDATA, 32'h0);
      chk("rx entry", {20'h0, rx_q.pop_front()}, rd_data);
    end
    apb(1'b0, `A_INFO, 32'h0);
    chk("rx empty", 32'h1, {31'h0, rd_data[10]});
  endtask
  task automatic t_reset();
    apb(1'b0, `A_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd_data);
    apb(1'b0, `A_WM, 32'h0);
    chk("wm", 32'h0, rd_data);
    apb(1'b0, `A_INFO, 32'h0);
    chk("info", 32'h0000_1600, rd_data);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
  endtask
  task automatic t_cbit();
    apb(1'b1, `A_CTRL, 32'h100);
    chk("cbit en", 32'h1, {31'h0, tx_ohbit_en});
    send_pkt(3, 8'hF8);
    wait_stat(0);
    apb(1'b0, `A_STAT, 32'h0);
    chk("rx ev", 32'h3, {30'h0, rd_data[6:5]});
    apb(1'b1, `A_STAT, 32'h60);
    drain();
  endtask
  task automatic t_b2b();
    send_pkt(2, 8'h7C);
    send_pkt(4, 8'h3E);
    wait_stat(0);
    wait_stat(0);
    drain();
  endtask
  task automatic t_e3();
    gap <= 8'd9;
    e3_sel <= 1'b1;
    apb(1'b1, `A_CTRL, 32'h600);
    chk("sn en", 32'h1, {31'h0, tx_ohbit_en});
    send_pkt(3, 8'h55);
    wait_stat(0);
    drain();
    apb(1'b1, `A_CTRL, 32'hE00);
    chk("sn off", 32'h0, {31'h0, tx_ohbit_en});
  endtask
  task automatic t_m23();
    gap <= 8'd4;
    e3_sel <= 1'b0;
    apb(1'b1, `A_CTRL, 32'h000);
    send_pkt(20, 8'h10);
    rx_q.delete();
    apb(1'b0, `A_INFO, 32'h0);
    chk("tx level", 32'h14, {19'h0, rd_data[12], 3'h0, rd_data[8:0]});
    apb(1'b1, `A_WM, 32'h73);
    apb(1'b0, `A_INFO, 32'h0);
    chk("low mark", 32'h1, {31'h0, rd_data[12]});
    repeat (200) @(posedge pclk);
    apb(1'b0, `A_INFO, 32'h0);
    chk("m23 idle", 32'h14, {23'h0, rd_data[8:0]});
    apb(1'b1, `A_CTRL, 32'h040);
    send_pkt(2, 8'h20);
    apb(1'b1, `A_CTRL, 32'h040);
    apb(1'b0, `A_INFO, 32'h0);
    chk("level held", 32'h2, {23'h0, rd_data[8:0]});
    apb(1'b1, `A_CTRL, 32'h080);
    apb(1'b1, `A_CTRL, 32'h040);
    rx_q.delete();
    apb(1'b0, `A_INFO, 32'h0);
    chk("flushed", 32'h200, {22'h0, rd_data[9:0]});
  endtask
  task automatic t_fill_underrun();
    apb(1'b1, `A_CTRL, 32'h108);
    repeat (100) @(posedge pclk);
    chk("idle fill", 32'hFF, {24'h0, last8});
    apb(1'b1, `A_CTRL, 32'h100);
    repeat (100) @(posedge pclk);
    chk("flag fill", 32'd6, 32'($countones(last8)));
    apb(1'b1, `A_STAT, 32'h10);
    apb(1'b1, `A_TXDATA, 32'h0A5);
    apb(1'b1, `A_TXDATA, 32'h05A);
    wait_stat(1);
    wait_stat(4);
    apb(1'b1, `A_CTRL, 32'h1C0);
    apb(1'b1, `A_CTRL, 32'h100);
    apb(1'b0, `A_INFO, 32'h0);
    chk("rx flushed", 32'h1, {31'h0, rd_data[10]});
  endtask
  task automatic report_and_stop();
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gap = 8'd4;
    e3_sel = 1'b0;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_cbit();
    t_b2b();
    t_e3();
    t_m23();
    t_fill_underrun();
    report_and_stop();
  end
endmodule
